/* rtl/tfpa_pkg.sv */
// Register map and constants of the timer flag and accumulator block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`default_nettype none

package tfpa_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 8;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_GATE_LAST = 6'h3F;
  localparam logic [7:0] IDX_FUNC_SEL = 8'h00;
  localparam logic [7:0] IDX_COUNTER = 8'h04;
  localparam logic [7:0] IDX_SYS_CTRL = 8'h06;
  localparam logic [7:0] IDX_IRQ_EN = 8'h0C;
  localparam logic [7:0] IDX_EVT_FLAGS = 8'h0E;
  localparam logic [7:0] IDX_OVF_FLAGS = 8'h0F;
  localparam logic [7:0] IDX_CHAN_BASE = 8'h10;
  localparam logic [7:0] IDX_CHAN_LAST = 8'h1E;
  localparam logic [7:0] IDX_ACC_CTRL = 8'h20;
  localparam logic [7:0] IDX_ACC_FLAGS = 8'h21;
  localparam logic [7:0] IDX_ACC_COUNT = 8'h22;
  localparam int SYS_TMR_EN_BIT = 7;
  localparam int SYS_FFCA_BIT = 4;
  localparam logic [7:0] SYS_CTRL_MASK = 8'h90;
  localparam int OVF_BIT = 7;
  localparam int ACC_EN_BIT = 6;
  localparam int ACC_MODE_BIT = 5;
  localparam int ACC_EDGE_BIT = 4;
  localparam int ACC_CLK_LSB = 2;
  localparam int ACC_OVI_BIT = 1;
  localparam int ACC_INI_BIT = 0;
  localparam logic [7:0] ACC_CTRL_MASK = 8'h7F;
  localparam int AFLG_OVF_BIT = 1;
  localparam int AFLG_IN_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_ACC_CTRL = 8'h00;
  localparam logic [CNT_W-1:0] RST_CHAN = 16'h0000;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [7:0] LOW_ALL_ONES = 8'hFF;
  localparam logic [1:0] CKS_PRESCALER = 2'h0;
  localparam logic [1:0] CKS_ACC = 2'h1;
  localparam logic [1:0] CKS_ACC_256 = 2'h2;
  localparam logic [1:0] CKS_ACC_64K = 2'h3;
endpackage

`default_nettype wire

/* rtl/tfpa_sync.sv */
// Two-flop synchroniser for the accumulator input pin
`default_nettype none

module tfpa_sync import tfpa_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

`default_nettype wire

/* rtl/tfpa_chan.sv */
// One capture/compare channel with its event flag
`default_nettype none

module tfpa_chan import tfpa_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic compare_mode,
  input wire logic capture_evt,
  input wire logic count_tick,
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] count_nxt,
  input wire logic value_wr,
  input wire logic [CNT_W-1:0] value_wdata,
  input wire logic flag_clr,
  output logic [CNT_W-1:0] value,
  output logic flag,
  output logic match
);
  logic [CNT_W-1:0] value_ff;
  logic [CNT_W-1:0] nxt_value;
  logic flag_ff;
  logic nxt_flag;
  logic capture_hit;
  logic compare_hit;

  assign compare_hit = compare_mode & count_tick & (count_nxt == value_ff);
  assign capture_hit = ~compare_mode & capture_evt;
  assign nxt_value = capture_hit ? count :
                     (value_wr & compare_mode) ? value_wdata : value_ff;
  // Set wins over clear
  assign nxt_flag = compare_hit | capture_hit | (flag_ff & ~flag_clr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_ff <= RST_CHAN;
      flag_ff <= 1'b0;
    end
    else
    begin
      value_ff <= nxt_value;
      flag_ff <= nxt_flag;
    end
  end

  assign value = value_ff;
  assign flag = flag_ff;
  assign match = compare_hit;
endmodule

`default_nettype wire

/* rtl/tfpa_top.sv */
// Timer flags, channel registers and pulse accumulator with APB slave
`default_nettype none

module tfpa_top import tfpa_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prescaler_tick,
  input wire logic [NCH-1:0] capture_event,
  input wire logic channel7_pin,
  output logic [NCH-1:0] compare_match,
  output logic [NCH-1:0] channel_irq,
  output logic accum_irq,
  output logic [CNT_W-1:0] free_running_counter
);

  //--------------------------------------------------------------------
  // Decode helpers
  //--------------------------------------------------------------------
  function automatic logic is_chan(input logic [7:0] idx);
    is_chan = (idx >= IDX_CHAN_BASE) && (idx <= IDX_CHAN_LAST) &&
              (idx[0] == 1'b0);
  endfunction

  function automatic logic [7:0] byte_word(input logic [7:0] b);
    byte_word = b;
  endfunction

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic [7:0] func_sel_ff;
  logic [7:0] nxt_func_sel;
  logic [7:0] sys_ctrl_ff;
  logic [7:0] nxt_sys_ctrl;
  logic [7:0] irq_en_ff;
  logic [7:0] nxt_irq_en;
  logic [7:0] acc_ctrl_ff;
  logic [7:0] nxt_acc_ctrl;
  logic ovf_flag_ff;
  logic nxt_ovf_flag;
  logic acc_ovf_ff;
  logic nxt_acc_ovf;
  logic acc_in_ff;
  logic nxt_acc_in;
  logic [CNT_W-1:0] counter_ff;
  logic [CNT_W-1:0] nxt_counter;
  logic [CNT_W-1:0] acc_count_ff;
  logic [CNT_W-1:0] nxt_acc_count;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic pin_d_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;

  //--------------------------------------------------------------------
  // Control fields
  //--------------------------------------------------------------------
  logic tmr_en;
  logic ffca;
  logic acc_en;
  logic acc_mode;
  logic acc_edge;
  logic [1:0] clk_sel;
  logic en_any;

  assign tmr_en = sys_ctrl_ff[SYS_TMR_EN_BIT];
  assign ffca = sys_ctrl_ff[SYS_FFCA_BIT];
  assign acc_en = acc_ctrl_ff[ACC_EN_BIT];
  assign acc_mode = acc_ctrl_ff[ACC_MODE_BIT];
  assign acc_edge = acc_ctrl_ff[ACC_EDGE_BIT];
  assign clk_sel = acc_ctrl_ff[ACC_CLK_LSB+1:ACC_CLK_LSB];
  assign en_any = tmr_en | acc_en;

  //--------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------
  logic [7:0] idx;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit_func;
  logic hit_cnt;
  logic hit_sys;
  logic hit_irq;
  logic hit_evt;
  logic hit_ovf;
  logic hit_actl;
  logic hit_aflg;
  logic hit_acnt;
  logic chan_hit;
  logic [2:0] chan_idx;
  logic [NCH-1:0] chan_onehot;
  logic mapped;

  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_func = addr_ok && (idx == IDX_FUNC_SEL);
  assign hit_cnt = addr_ok && (idx == IDX_COUNTER);
  assign hit_sys = addr_ok && (idx == IDX_SYS_CTRL);
  assign hit_irq = addr_ok && (idx == IDX_IRQ_EN);
  assign hit_evt = addr_ok && (idx == IDX_EVT_FLAGS);
  assign hit_ovf = addr_ok && (idx == IDX_OVF_FLAGS);
  assign hit_actl = addr_ok && (idx == IDX_ACC_CTRL);
  assign hit_aflg = addr_ok && (idx == IDX_ACC_FLAGS);
  assign hit_acnt = addr_ok && (idx == IDX_ACC_COUNT);
  assign chan_hit = addr_ok && is_chan(idx);
  assign chan_idx = idx[3:1];
  assign chan_onehot = chan_hit ? (8'h01 << chan_idx) : 8'h00;
  assign mapped = hit_func | hit_cnt | hit_sys | hit_irq | hit_evt |
                  hit_ovf | hit_actl | hit_aflg | hit_acnt | chan_hit;

  //--------------------------------------------------------------------
  // Accumulator input pin
  //--------------------------------------------------------------------
  logic pin_s;
  logic pin_rise;
  logic pin_fall;
  logic in_edge;
  logic gate_level;

  tfpa_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(channel7_pin),
    .sync_out(pin_s)
  );

  assign pin_rise = pin_s & ~pin_d_ff;
  assign pin_fall = ~pin_s & pin_d_ff;
  // Counting edge and gated trailing edge coincide
  assign in_edge = acc_edge ? pin_rise : pin_fall;
  assign gate_level = acc_edge ? ~pin_s : pin_s;

  //--------------------------------------------------------------------
  // Divide-by-64 gating clock
  //--------------------------------------------------------------------
  logic div64_tick;

  assign nxt_div = tmr_en ? div_ff + 6'h01 : '0;
  assign div64_tick = tmr_en && (div_ff == DIV_GATE_LAST);

  //--------------------------------------------------------------------
  // Accumulator clock and count
  //--------------------------------------------------------------------
  logic acc_clk;
  logic acc_wrap;
  logic acc_carry8;

  assign acc_clk = acc_en & (acc_mode ? (gate_level & div64_tick)
                                    : in_edge);
  assign acc_wrap = acc_clk && (acc_count_ff == CNT_ALL_ONES);
  assign acc_carry8 = acc_clk && (acc_count_ff[7:0] == LOW_ALL_ONES);
  assign nxt_acc_count = acc_clk ? acc_count_ff + 16'h0001 : acc_count_ff;

  //--------------------------------------------------------------------
  // Timer counter clock select
  //--------------------------------------------------------------------
  logic [1:0] eff_sel;
  logic src_tick;
  logic cnt_tick;
  logic cnt_wrap;

  assign eff_sel = acc_en ? clk_sel : CKS_PRESCALER;
  assign src_tick = (eff_sel == CKS_ACC) ? acc_clk :
                    (eff_sel == CKS_ACC_256) ? acc_carry8 :
                    (eff_sel == CKS_ACC_64K) ? acc_wrap :
                    prescaler_tick;
  assign cnt_tick = tmr_en & src_tick;
  assign cnt_wrap = cnt_tick && (counter_ff == CNT_ALL_ONES);
  assign nxt_counter = cnt_tick ? counter_ff + 16'h0001 : counter_ff;

  //--------------------------------------------------------------------
  // Channels
  //--------------------------------------------------------------------
  logic [NCH-1:0] chan_flag;
  logic [NCH-1:0] chan_clr;
  logic [NCH-1:0] fast_clr;
  logic [NCH-1:0] w1c_clr;
  logic [NCH-1:0] value_wr;
  logic [CNT_W-1:0] chan_value [NCH];

  assign w1c_clr = {NCH{wr & hit_evt & en_any}} & pwdata[NCH-1:0];
  // Read in capture mode or write in compare mode
  assign fast_clr = {NCH{ffca & access}} & chan_onehot &
                    ~(func_sel_ff ^ {NCH{pwrite}});
  assign chan_clr = w1c_clr | fast_clr;
  assign value_wr = {NCH{wr}} & chan_onehot;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      tfpa_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .compare_mode(func_sel_ff[g]),
        .capture_evt(capture_event[g]),
        .count_tick(cnt_tick),
        .count(counter_ff),
        .count_nxt(nxt_counter),
        .value_wr(value_wr[g]),
        .value_wdata(pwdata[CNT_W-1:0]),
        .flag_clr(chan_clr[g]),
        .value(chan_value[g]),
        .flag(chan_flag[g]),
        .match(compare_match[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------------
  // Flags
  //--------------------------------------------------------------------
  logic ovf_clr;
  logic aovf_clr;
  logic ain_clr;
  logic acnt_fast;

  assign ovf_clr = (wr & hit_ovf & en_any & pwdata[OVF_BIT]) |
                   (ffca & access & hit_cnt);
  assign nxt_ovf_flag = cnt_wrap | (ovf_flag_ff & ~ovf_clr);
  assign acnt_fast = ffca & access & hit_acnt;
  assign aovf_clr = (wr & hit_aflg & en_any & pwdata[AFLG_OVF_BIT]) |
                    acnt_fast;
  assign ain_clr = (wr & hit_aflg & en_any & pwdata[AFLG_IN_BIT]) |
                   acnt_fast;
  assign nxt_acc_ovf = acc_wrap | (acc_ovf_ff & ~aovf_clr);
  assign nxt_acc_in = (acc_en & in_edge) | (acc_in_ff & ~ain_clr);

  //--------------------------------------------------------------------
  // Writable registers
  //--------------------------------------------------------------------
  assign nxt_func_sel = (wr & hit_func) ? pwdata[7:0] : func_sel_ff;
  assign nxt_sys_ctrl = (wr & hit_sys) ? (pwdata[7:0] & SYS_CTRL_MASK)
                                       : sys_ctrl_ff;
  assign nxt_irq_en = (wr & hit_irq) ? pwdata[7:0] : irq_en_ff;
  assign nxt_acc_ctrl = (wr & hit_actl) ? (pwdata[7:0] & ACC_CTRL_MASK)
                                        : acc_ctrl_ff;

  //--------------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------------
  logic [7:0] ovf_byte;
  logic [7:0] aflg_byte;
  logic [31:0] rd_word;

  assign ovf_byte = {ovf_flag_ff, 7'h00};
  assign aflg_byte = {6'h00, acc_ovf_ff, acc_in_ff};
  assign rd_word = chan_hit ? {16'h0000, chan_value[chan_idx]} :
                   hit_func ? {24'h000000, byte_word(func_sel_ff)} :
                   hit_cnt ? {16'h0000, counter_ff} :
                   hit_sys ? {24'h000000, byte_word(sys_ctrl_ff)} :
                   hit_irq ? {24'h000000, byte_word(irq_en_ff)} :
                   hit_evt ? {24'h000000, byte_word(chan_flag)} :
                   hit_ovf ? {24'h000000, ovf_byte} :
                   hit_actl ? {24'h000000, byte_word(acc_ctrl_ff)} :
                   hit_aflg ? {24'h000000, aflg_byte} :
                   hit_acnt ? {16'h0000, acc_count_ff} :
                   32'h00000000;
  assign nxt_prdata = setup ? rd_word : prdata_ff;
  assign nxt_pslverr = setup ? ~mapped : pslverr_ff;

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_sel_ff <= RST_BYTE;
      sys_ctrl_ff <= RST_BYTE;
      irq_en_ff <= RST_BYTE;
      acc_ctrl_ff <= RST_ACC_CTRL;
    end
    else
    begin
      func_sel_ff <= nxt_func_sel;
      sys_ctrl_ff <= nxt_sys_ctrl;
      irq_en_ff <= nxt_irq_en;
      acc_ctrl_ff <= nxt_acc_ctrl;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_flag_ff <= 1'b0;
      acc_ovf_ff <= 1'b0;
      acc_in_ff <= 1'b0;
      pin_d_ff <= 1'b0;
    end
    else
    begin
      ovf_flag_ff <= nxt_ovf_flag;
      acc_ovf_ff <= nxt_acc_ovf;
      acc_in_ff <= nxt_acc_in;
      pin_d_ff <= pin_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_ff <= RST_COUNT;
      acc_count_ff <= RST_COUNT;
      div_ff <= '0;
    end
    else
    begin
      counter_ff <= nxt_counter;
      acc_count_ff <= nxt_acc_count;
      div_ff <= nxt_div;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = access;
  assign pslverr = access & pslverr_ff;
  assign free_running_counter = counter_ff;
  assign channel_irq = chan_flag & irq_en_ff;
  assign accum_irq = (acc_ovf_ff & acc_ctrl_ff[ACC_OVI_BIT]) |
                     (acc_in_ff & acc_ctrl_ff[ACC_INI_BIT]);

endmodule

`default_nettype wire

/* sim/tfpa_sva.sv */
// Checker of bus answers, counter steps and flag clearing
`default_nettype none

module tfpa_sva import tfpa_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic prescaler_tick,
  input wire logic [NCH-1:0] capture_event,
  input wire logic channel7_pin,
  input wire logic [NCH-1:0] compare_match,
  input wire logic [NCH-1:0] channel_irq,
  input wire logic accum_irq,
  input wire logic [CNT_W-1:0] free_running_counter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_no_wait:
    assert property (pready == (psel && penable))
    else $error("pready outside access cycle");
  chk_err_in_access:
    assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access cycle");
  chk_err_read_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  chk_rdata_stands:
    assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("prdata moved outside setup");
  chk_cnt_step:
    assert property ($changed(free_running_counter) |->
      free_running_counter == $past(free_running_counter) + 16'h0001)
    else $error("counter did not step by one");
  chk_match_tick:
    assert property (|compare_match |=>
      free_running_counter == $past(free_running_counter) + 16'h0001)
    else $error("match without counter tick");
  chk_match_once:
    assert property (|compare_match |=>
      (compare_match & $past(compare_match)) == 8'h00)
    else $error("match longer than one cycle");
  chk_chirq_clear:
    assert property ((|($past(channel_irq) & ~channel_irq)) |->
      $past(psel && penable))
    else $error("channel irq fell without access");
  chk_accirq_clear:
    assert property ($fell(accum_irq) |-> $past(psel && penable))
    else $error("accumulator irq fell without access");
endmodule

bind tfpa_top tfpa_sva #(.ADDR_W(ADDR_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .prescaler_tick(prescaler_tick),
  .capture_event(capture_event), .channel7_pin(channel7_pin),
  .compare_match(compare_match), .channel_irq(channel_irq),
  .accum_irq(accum_irq), .free_running_counter(free_running_counter));

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the timer flag and accumulator block
`default_nettype none

module tb_top import tfpa_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic prescaler_tick = 1'b0;
  logic [NCH-1:0] capture_event = '0;
  logic channel7_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCH-1:0] compare_match;
  logic [NCH-1:0] channel_irq;
  logic accum_irq;
  logic [CNT_W-1:0] frc;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int checks = 0;

  tfpa_top #(.ADDR_W(AW)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescaler_tick(prescaler_tick),
    .capture_event(capture_event), .channel7_pin(channel7_pin),
    .compare_match(compare_match), .channel_irq(channel_irq),
    .accum_irq(accum_irq), .free_running_counter(frc));

  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus, compare and stimulus tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] i,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("BAD %0t no pready", $time);
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] e,
    input string m);
    apb(1'b0, i, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic tick(input int n);
    prescaler_tick <= 1'b1;
    idle(n);
    prescaler_tick <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cap1();
    capture_event <= 8'h02;
    @(posedge pclk);
    capture_event <= 8'h00;
    @(posedge pclk);
  endtask

  task automatic pin(input logic v);
    channel7_pin <= v;
    idle(6);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle(5);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_ACC_CTRL, 32'h0, "ctrl reset");
    rdc(IDX_CHAN_BASE + 8'h02, 32'h0, "chan reset");
    wr(IDX_ACC_CTRL, 32'hFF);
    rdc(IDX_ACC_CTRL, 32'h7F, "ctrl bit7");
    wr(IDX_ACC_CTRL, 32'h00);
    apb(1'b0, 8'hFF, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    $display("test registers done");
    wr(IDX_FUNC_SEL, 32'h01);
    wr(IDX_CHAN_BASE, 32'h1234);
    rdc(IDX_CHAN_BASE, 32'h1234, "compare write");
    wr(IDX_CHAN_BASE + 8'h02, 32'h5555);
    rdc(IDX_CHAN_BASE + 8'h02, 32'h0, "capture write");
    wr(IDX_IRQ_EN, 32'h02);
    cap1();
    wr(IDX_EVT_FLAGS, 32'h02);
    rdc(IDX_EVT_FLAGS, 32'h02, "clear disabled");
    chk(channel_irq, 32'h02, "channel irq");
    wr(IDX_SYS_CTRL, 32'h80);
    tick(5);
    cap1();
    rdc(IDX_CHAN_BASE + 8'h02, 32'h5, "capture value");
    wr(IDX_EVT_FLAGS, 32'h00);
    rdc(IDX_EVT_FLAGS, 32'h02, "write zero");
    wr(IDX_EVT_FLAGS, 32'h02);
    rdc(IDX_EVT_FLAGS, 32'h0, "write one");
    wr(IDX_SYS_CTRL, 32'h90);
    tick(1);
    cap1();
    rdc(IDX_CHAN_BASE + 8'h02, 32'h6, "capture again");
    rdc(IDX_EVT_FLAGS, 32'h0, "fast read clear");
    $display("test channels done");
    tick(65530);
    rdc(IDX_OVF_FLAGS, 32'h80, "overflow");
    rdc(IDX_EVT_FLAGS, 32'h01, "compare flag");
    rdc(IDX_COUNTER, 32'h0, "wrapped");
    rdc(IDX_OVF_FLAGS, 32'h0, "fast overflow clear");
    wr(IDX_CHAN_BASE, 32'h1234);
    rdc(IDX_EVT_FLAGS, 32'h0, "fast write clear");
    $display("test overflow done");
    wr(IDX_SYS_CTRL, 32'h10);
    wr(IDX_ACC_CTRL, 32'h51);
    pin(1'b1);
    chk(accum_irq, 32'h1, "input irq");
    rdc(IDX_ACC_COUNT, 32'h1, "rising counted");
    pin(1'b0);
    rdc(IDX_ACC_COUNT, 32'h1, "falling ignored");
    chk(accum_irq, 32'h0, "irq cleared");
    $display("test events done");
    wr(IDX_SYS_CTRL, 32'h90);
    wr(IDX_ACC_CTRL, 32'h44);
    pin(1'b1);
    pin(1'b0);
    rdc(IDX_COUNTER, 32'h1, "accum clock");
    wr(IDX_ACC_CTRL, 32'h04);
    pin(1'b1);
    pin(1'b0);
    tick(1);
    rdc(IDX_COUNTER, 32'h2, "prescaler forced");
    chk(frc, 32'h2, "counter port");
    $display("test clock select done");
    wr(IDX_SYS_CTRL, 32'h10);
    wr(IDX_ACC_CTRL, 32'h61);
    wr(IDX_ACC_FLAGS, 32'h03);
    pin(1'b1);
    idle(200);
    chk(accum_irq, 32'h0, "leading edge");
    pin(1'b0);
    chk(accum_irq, 32'h1, "trailing edge");
    wr(IDX_ACC_FLAGS, 32'h01);
    chk(accum_irq, 32'h0, "flag w1c");
    rdc(IDX_ACC_COUNT, 32'h2, "no gate clock");
    wr(IDX_SYS_CTRL, 32'h90);
    pin(1'b1);
    idle(200);
    pin(1'b0);
    rdc(IDX_ACC_COUNT, 32'h5, "gated count");
    $display("test gated done");
    close_out();
  end
endmodule

`default_nettype wire
